// *** include/ssp_defines.vh ***
// Constants of the sensor serial register port
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
`define SSP_WORD_BITS      16
`define SSP_REG_COUNT      32
`define SSP_CNT_BITS       5
`define SSP_RW_BIT         15
`define SSP_ADDR_HI        14
`define SSP_ADDR_LO        8
`define SSP_IDX_HI         13
`define SSP_IDX_LO         9
`define SSP_BYTE_SEL       8
`define SSP_FRAME_BITS     5'h10
`define SSP_IDX_FLASHCNT   5'h00
`define SSP_IDX_BUFFX      5'h0A
`define SSP_IDX_BUFFY      5'h0B
`define SSP_IDX_BUFFZ      5'h0C
`define SSP_IDX_GLOBCMD    5'h1F
`define SSP_FLASH_UPD_BIT  4
`define SSP_BACKUP_MASK    32'h1A1FC3EF
`define SSP_WRITE_MASK     32'h1E1FE00E
`define SSP_RDONLY_MASK    32'h00001FE1
`define SSP_DEF_OUT_LO     5
`define SSP_DEF_OUT_HI     12
`define SSP_DEF_OUT        16'h8000
`define SSP_IDX_CAPTCTRL   5'h0E
`define SSP_DEF_CAPTCTRL   16'h0020
`define SSP_IDX_DIOCTRL    5'h1B
`define SSP_DEF_DIOCTRL    16'h000F
`define SSP_DEF_ZERO       16'h0000
`endif

// *** design/ssp_sensor_spi_port.v ***
// Serial slave register port with working and flash register copies
// Summary of operation
// - Each input bit is taken from the data input on a rising serial clock.
// - Each output bit is shifted onto the data output on a falling clock.
// - The data output is driven only while chip select is low.
// - Every register is 16 bits with separate upper and lower byte addresses.
// - The output returns what an earlier input command requested.
// - A working copy governs operation and takes writes; flash backs some.
// - Backed-up registers go to flash only on global command bit 12 (0xBF10).
// - After reset flash loads into working registers before data starts.
// - Acceleration samples are stored and read back through the registers.
// - The link is clock polarity 1 phase 1, MSB first, 16-bit words.
// - A read is a request frame then a frame that returns the contents.
// - A write frame updates one byte of one register.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.vh"
module ssp_sensor_spi_port (
  input  wire         clk,          // System clock, 100 MHz
  input  wire         rst_n,        // Asynchronous reset, active low
  input  wire         spiSclk,      // Serial clock from master
  input  wire         spiCs_n,      // Chip select, active low
  input  wire         spiDin,       // Serial data in
  output reg          spiDout,      // Serial data out
  output reg          spiDoutOe_n,  // Output enable, low while driving
  input  wire [15:0]  sampleX,      // Processed x sample
  input  wire [15:0]  sampleY,      // Processed y sample
  input  wire [15:0]  sampleZ,      // Processed z sample
  input  wire         sampleValid,  // Pulse, samples valid
  output reg          cfgReady,     // High once configuration restored
  output wire [511:0] cfgWords      // Readable working registers, word i at i*16, zero where not readable
);
  reg        sclkS1_q, sclkS2_q, sclkS3_q;
  reg        csS1_q, csS2_q;
  reg        dinS1_q, dinS2_q;
  reg [15:0] rxShift_q;
  reg [15:0] rxShift_d;
  reg [15:0] txShift_q;
  reg [15:0] txShift_d;
  reg        spiDout_d;
  reg [4:0]  bitCnt_q;
  reg [4:0]  bitCnt_d;
  reg        restore_q;
  reg        frameDone_q;
  reg        frameDone_d;
  reg [15:0] frame_q;
  reg [15:0] frame_d;

  wire sclkRise = sclkS2_q & ~sclkS3_q;
  wire sclkFall = ~sclkS2_q & sclkS3_q;
  wire csActive = ~csS2_q;

  // Decoded command of the completed frame
  wire [4:0] cmdIdx   = frame_q[`SSP_IDX_HI:`SSP_IDX_LO];
  wire       cmdWrite = frame_q[`SSP_RW_BIT];
  wire       cmdUpper = frame_q[`SSP_BYTE_SEL];
  wire [7:0] cmdData  = frame_q[7:0];
  wire       flashCmd = frameDone_q & cmdWrite & ~restore_q &
                        (cmdIdx == `SSP_IDX_GLOBCMD) & cmdUpper &
                        cmdData[`SSP_FLASH_UPD_BIT];
  wire       wrEn     = frameDone_q & cmdWrite & ~restore_q;

  wire [31:0] bkMask = `SSP_BACKUP_MASK;
  wire [31:0] wrMask = `SSP_WRITE_MASK;
  wire [31:0] rdMask = `SSP_BACKUP_MASK | `SSP_WRITE_MASK |
                       `SSP_RDONLY_MASK;

  // Two-flop synchronisers for all pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkS1_q <= 1'b1;
      sclkS2_q <= 1'b1;
      sclkS3_q <= 1'b1;
      csS1_q   <= 1'b1;
      csS2_q   <= 1'b1;
      dinS1_q  <= 1'b0;
      dinS2_q  <= 1'b0;
    end else begin
      sclkS1_q <= spiSclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      csS1_q   <= spiCs_n;
      csS2_q   <= csS1_q;
      dinS1_q  <= spiDin;
      dinS2_q  <= dinS1_q;
    end
  end

  // One cycle restore from flash after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restore_q <= 1'b1;
      cfgReady  <= 1'b0;
    end else begin
      restore_q <= 1'b0;
      cfgReady  <= ~restore_q;
    end
  end

  // Receive side: mode 3, MSB first, 16-bit frames
  // Deselect drops a partial frame so the next one starts aligned
  always @* begin
    rxShift_d   = rxShift_q;
    bitCnt_d    = bitCnt_q;
    frameDone_d = 1'b0;
    frame_d     = frame_q;
    if (!csActive) begin
      bitCnt_d = 5'h00;
    end else if (sclkRise) begin
      rxShift_d = {rxShift_q[14:0], dinS2_q};
      if (bitCnt_q == `SSP_FRAME_BITS - 5'h01) begin
        bitCnt_d    = 5'h00;
        frameDone_d = 1'b1;
        frame_d     = {rxShift_q[14:0], dinS2_q};
      end else begin
        bitCnt_d = bitCnt_q + 5'h01;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_q   <= 16'h0000;
      bitCnt_q    <= 5'h00;
      frameDone_q <= 1'b0;
      frame_q     <= 16'h0000;
    end else begin
      rxShift_q   <= rxShift_d;
      bitCnt_q    <= bitCnt_d;
      frameDone_q <= frameDone_d;
      frame_q     <= frame_d;
    end
  end

  // Working and flash copies, one word per generate step
  genvar i;
  generate
    for (i = 0; i < `SSP_REG_COUNT; i = i + 1) begin : gReg
      localparam [15:0] DEF =
        (i >= `SSP_DEF_OUT_LO && i <= `SSP_DEF_OUT_HI) ? `SSP_DEF_OUT :
        (i == `SSP_IDX_CAPTCTRL) ? `SSP_DEF_CAPTCTRL :
        (i == `SSP_IDX_DIOCTRL)  ? `SSP_DEF_DIOCTRL  : `SSP_DEF_ZERO;
      reg [15:0] work_q;
      reg [15:0] work_d;
      reg [15:0] flash_q;
      reg [15:0] flash_d;
      wire       hit = wrEn & (cmdIdx == i) & wrMask[i];
      // Flash is nonvolatile: factory contents, no reset
      initial flash_q = DEF;
      // Flash count word records how many updates were made
      always @* begin
        flash_d = flash_q;
        if (flashCmd && bkMask[i]) begin
          if (i == `SSP_IDX_FLASHCNT)
            flash_d = work_q + 16'h0001;
          else
            flash_d = work_q;
        end
      end
      always @(posedge clk) begin
        flash_q <= flash_d;
      end
      // Restore beats everything so no write lands before data starts
      always @* begin
        work_d = work_q;
        if (restore_q) begin
          work_d = bkMask[i] ? flash_q : DEF;
        end else if (flashCmd && i == `SSP_IDX_FLASHCNT) begin
          work_d = work_q + 16'h0001;
        end else if (hit && cmdUpper) begin
          work_d[15:8] = cmdData;
        end else if (hit) begin
          work_d[7:0] = cmdData;
        end else if (sampleValid && i == `SSP_IDX_BUFFX) begin
          work_d = sampleX;
        end else if (sampleValid && i == `SSP_IDX_BUFFY) begin
          work_d = sampleY;
        end else if (sampleValid && i == `SSP_IDX_BUFFZ) begin
          work_d = sampleZ;
        end
      end
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          work_q <= DEF;
        end else begin
          work_q <= work_d;
        end
      end
      assign cfgWords[i*16 +: 16] = rdMask[i] ? work_q : 16'h0000;
    end
  endgenerate

  wire [15:0] rdWord = cfgWords[cmdIdx*16 +: 16];

  // Transmit side: reply loaded at frame end, shifted on falling edges
  // Write frames answer with zero in the following frame
  always @* begin
    txShift_d = txShift_q;
    spiDout_d = spiDout;
    if (frameDone_q) begin
      txShift_d = cmdWrite ? 16'h0000 : rdWord;
    end else if (csActive && sclkFall) begin
      spiDout_d = txShift_q[15];
      txShift_d = {txShift_q[14:0], 1'b0};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift_q   <= 16'h0000;
      spiDout     <= 1'b0;
      spiDoutOe_n <= 1'b1;
    end else begin
      spiDoutOe_n <= ~csActive;
      txShift_q   <= txShift_d;
      spiDout     <= spiDout_d;
    end
  end
endmodule
`default_nettype wire

// *** tb/ssp_master_model.sv ***
// Serial master model issuing mode 3 frames
`timescale 1ns/1ns
`default_nettype none
module ssp_master_model (
  output var logic spiSclk, // Serial clock
  output var logic spiCs_n, // Chip select
  output var logic spiDin,  // Data to device
  input  wire logic spiMiso // Resolved return line
);
  initial begin
    spiSclk = 1'b1;
    spiCs_n = 1'b1;
    spiDin = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    integer i;
    spiCs_n = 1'b0;
    #63;
    for (i = 15; i >= 0; i--) begin
      spiSclk = 1'b0;
      spiDin = w[i];
      #62 spiSclk = 1'b1;
      r[i] = spiMiso;
      #63;
    end
    #200 spiCs_n = 1'b1;
    spiDin = ~spiDin;
    #15400;
  endtask
endmodule
`default_nettype wire

// *** tb/ssp_port_monitor.sv ***
// Assertion checker for the serial register port
`timescale 1ns/1ns
`default_nettype none
module ssp_port_monitor (
  input wire logic         clk,         // Clock
  input wire logic         rst_n,       // Reset
  input wire logic         spiSclk,     // Serial clock
  input wire logic         spiCs_n,     // Select
  input wire logic         spiDout,     // Data out
  input wire logic         spiDoutOe_n, // Out enable
  input wire logic [15:0]  sampleX,     // X sample
  input wire logic         sampleValid, // Sample strobe
  input wire logic         cfgReady,    // Restore done
  input wire logic [511:0] cfgWords     // Working words
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence csIdle; spiCs_n[*4]; endsequence
  sequence csBusy; !spiCs_n[*4]; endsequence
  oe_off_a: assert property (csIdle |-> spiDoutOe_n)
    else $error("output driven while deselected");
  oe_on_a: assert property (csBusy |-> !spiDoutOe_n)
    else $error("output not driven while selected");
  dout_fall_a: assert property ($changed(spiDout) && !spiDoutOe_n
    |-> !($past(spiSclk,1) && $past(spiSclk,2) && $past(spiSclk,3)))
    else $error("output bit moved away from falling edge");
  ready_rise_a: assert property ($rose(rst_n) |-> !cfgReady ##2 cfgReady)
    else $error("restore timing wrong");
  ready_hold_a: assert property (cfgReady |=> cfgReady)
    else $error("restore flag dropped");
  capt_load_a: assert property (sampleValid |=> cfgWords[175:160] == $past(sampleX))
    else $error("capture word not loaded");
  write_cs_a: assert property ($changed(cfgWords[255:240]) && cfgReady
    |-> !$past(spiCs_n,4))
    else $error("register changed outside a frame");
  cmd_zero_a: assert property (cfgReady |-> cfgWords[511:496] == 16'h0000)
    else $error("command word stored a value");
endmodule
bind ssp_sensor_spi_port ssp_port_monitor mon (.clk, .rst_n, .spiSclk,
  .spiCs_n, .spiDout, .spiDoutOe_n, .sampleX, .sampleValid, .cfgReady,
  .cfgWords);
`default_nettype wire

// *** tb/ssp_sensor_spi_port_tb.sv ***
// Self-checking bench for the serial register port
`timescale 1ns/1ns
`default_nettype none
module ssp_sensor_spi_port_tb;
  logic         clk, rst_n, spiSclk, spiCs_n, spiDin, spiDout, spiDoutOe_n;
  logic         sampleValid, cfgReady;
  logic [15:0]  sampleX, r, c;
  logic [511:0] cfgWords;
  integer       mismatches = 0, n_tests = 0, cycles = 0;
  wire          spiMiso = spiDoutOe_n ? ~spiDout : spiDout;
  ssp_sensor_spi_port uut (.clk, .rst_n, .spiSclk, .spiCs_n, .spiDin,
    .spiDout, .spiDoutOe_n, .sampleX, .sampleY(~sampleX),
    .sampleZ({sampleX[7:0], sampleX[15:8]}), .sampleValid, .cfgReady,
    .cfgWords);
  ssp_master_model master (.spiSclk, .spiCs_n, .spiDin, .spiMiso);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 70000) begin
      mismatches++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    master.xfer({1'b0, a, 8'h00}, r);
    master.xfer(16'h0000, r);
    chk("register read", exp, r);
  endtask
  task automatic reset_dut;
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    chk("restore done", 16'h0001, {15'h0000, cfgReady});
  endtask
  task automatic t_write;
    master.xfer(16'h9F12, r);
    master.xfer(16'h9E34, r);
    rd(7'h1E, 16'h1234);
    chk("working word", 16'h1234, cfgWords[255:240]);
  endtask
  task automatic t_capture;
    @(posedge clk);
    #1 sampleX = 16'hA5C3;
    sampleValid = 1'b1;
    @(posedge clk);
    #1 sampleValid = 1'b0;
    master.xfer(16'h9455, r);
    rd(7'h14, 16'hA5C3);
    rd(7'h16, 16'h5A3C);
    rd(7'h18, 16'hC3A5);
  endtask
  task automatic t_flash;
    master.xfer(16'h0000, r);
    master.xfer(16'hBF10, r);
    c = r;
    chk("flash count", 16'h0000, c);
    rd(7'h00, c + 16'h0001);
    master.xfer(16'h9E56, r);
    master.xfer(16'hB407, r);
    rd(7'h1E, 16'h1256);
    reset_dut();
    rd(7'h1E, 16'h1234);
    rd(7'h34, 16'h0000);
  endtask
  initial begin
    rst_n = 1'b0;
    sampleX = 16'h0000;
    sampleValid = 1'b0;
    reset_dut();
    rd(7'h1C, 16'h0020);
    rd(7'h36, 16'h000F);
    t_write();
    t_capture();
    t_flash();
    results();
  end
endmodule
`default_nettype wire
